// [rtl/stc_regs.vh]
`ifndef STC_REGS_VH
`define STC_REGS_VH
// Summary of operation
// - 16-bit internal timer/counter; no pin driven by compare or match.
// - counter ticks at main clock divided by 2,4,8,16,64,256,1024,2048 per 3-bit select.
// - mode control at 0xce, reset 0: enable b7, capture b5, clock b4:2, pause b1, start b0.
// - enable on when set; capture mode when set; pause bit clear stops counting.
// - read 0xcf in timer mode returns counter low byte, reset zero.
// - write 0xcf loads compare low byte, write-only, reset all ones.
// - read 0xcf in capture mode returns captured count low byte, reset zero.
// - read 0xd5 in timer mode returns counter high byte, reset zero.
// - write 0xd5 loads compare high byte, reset zero.
// - read 0xd5 in capture mode returns captured count high byte, reset zero.
// - writing one to start clears counter and starts; zero stops it.
// - sticky event flag readable while masked; write one clears it.
// ===========================================
// offsets
`define STC_ADDR_CTRL 8'hce
`define STC_ADDR_LOW 8'hcf
`define STC_ADDR_HIGH 8'hd5
`define STC_ADDR_STAT 8'hd6
`define STC_ADDR_MASK 8'hd7
// ===========================================
// control fields
`define STC_BIT_EN 7
`define STC_BIT_CAP 5
`define STC_CK_HI 4
`define STC_CK_LO 2
`define STC_BIT_CONT 1
`define STC_BIT_START 0
`define STC_CTRL_WMASK 8'hbf
// ===========================================
// reset values
`define STC_RST_CTRL 8'h00
`define STC_RST_CMPL 8'hff
`define STC_RST_CMPH 8'h00
`define STC_RST_CNT 16'h0000
`define STC_RST_CAP 16'h0000
`define STC_RST_STAT 8'h00
`define STC_RST_MASK 8'h00
// ===========================================
// status bits and timing
`define STC_BIT_MATCH 0
`define STC_BIT_CAPEV 1
`define STC_PRE_W 11
`endif

// [rtl/stc_prescaler.v]
`timescale 1ns/1ns
`include "stc_regs.vh"
// one-cycle tick at the main clock divided by the selected ratio
module stc_prescaler #(
	parameter W = `STC_PRE_W
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire run,
	input wire [2:0] sel,
	// tick out
	output reg tick
);
	reg [W-1:0] div_q;
	reg [W-1:0] lim;
	always @* begin
		case (sel)
			3'h0: lim = 11'h001;
			3'h1: lim = 11'h003;
			3'h2: lim = 11'h007;
			3'h3: lim = 11'h00f;
			3'h4: lim = 11'h03f;
			3'h5: lim = 11'h0ff;
			3'h6: lim = 11'h3ff;
			default: lim = 11'h7ff;
		endcase
	end
	always @(posedge clk) begin
		if (rst || !run) begin
			div_q <= {W{1'b0}};
			tick <= 1'b0;
		end else begin
			tick <= (div_q >= lim);
			if (div_q >= lim)
				div_q <= {W{1'b0}};
			else
				div_q <= div_q + 1'b1;
		end
	end
endmodule // stc_prescaler

// [rtl/stc_timer.v]
`timescale 1ns/1ns
`include "stc_regs.vh"
module stc_timer (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire [7:0] addr,
	input wire [7:0] wrData,
	input wire wrEn,
	input wire rdEn,
	output reg [7:0] rdData,
	// capture trigger from same clock domain
	input wire captureTrigger,
	// interrupt
	output wire irq
);
	// ===========================================
	// registers
	reg [7:0] ctrl_q;
	reg [7:0] cmpLow_q;
	reg [7:0] cmpHigh_q;
	reg [15:0] count_q;
	reg [15:0] capture_q;
	reg [7:0] stat_q;
	reg [7:0] mask_q;
	reg trigPrev_q;
	wire opOn = ctrl_q[`STC_BIT_EN];
	wire capMode = ctrl_q[`STC_BIT_CAP];
	wire counting = opOn & ctrl_q[`STC_BIT_START] & ctrl_q[`STC_BIT_CONT];
	wire tick;
	wire [15:0] compare = {cmpHigh_q, cmpLow_q};
	wire ctrlWr = wrEn && addr == `STC_ADDR_CTRL;
	wire startWr = ctrlWr && wrData[`STC_BIT_START];
	wire matchEv = tick && !capMode && count_q == compare;
	wire capEv = opOn && capMode && captureTrigger && !trigPrev_q;
	// ===========================================
	// prescaler
	stc_prescaler #(.W(`STC_PRE_W)) uPre (
		.clk(clk),
		.rst(rst),
		.run(counting),
		.sel(ctrl_q[`STC_CK_HI:`STC_CK_LO]),
		.tick(tick)
	);
	// ===========================================
	// control and compare
	always @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `STC_RST_CTRL;
			cmpLow_q <= `STC_RST_CMPL;
			cmpHigh_q <= `STC_RST_CMPH;
			mask_q <= `STC_RST_MASK;
		end else if (wrEn) begin
			if (ctrlWr)
				ctrl_q <= wrData & `STC_CTRL_WMASK;
			if (addr == `STC_ADDR_LOW)
				cmpLow_q <= wrData;
			if (addr == `STC_ADDR_HIGH)
				cmpHigh_q <= wrData;
			if (addr == `STC_ADDR_MASK)
				mask_q <= wrData;
		end
	end
	// ===========================================
	// counter and capture; nothing here drives a pin
	always @(posedge clk) begin
		if (rst) begin
			count_q <= `STC_RST_CNT;
			capture_q <= `STC_RST_CAP;
			trigPrev_q <= 1'b0;
		end else begin
			trigPrev_q <= captureTrigger;
			if (startWr)
				count_q <= `STC_RST_CNT;
			else if (matchEv)
				count_q <= `STC_RST_CNT;
			else if (tick)
				count_q <= count_q + 16'h0001;
			if (capEv)
				capture_q <= count_q;
		end
	end
	// ===========================================
	// sticky status, set wins over clear
	always @(posedge clk) begin
		if (rst) begin
			stat_q <= `STC_RST_STAT;
		end else begin
			if (wrEn && addr == `STC_ADDR_STAT)
				stat_q <= stat_q & ~wrData;
			if (matchEv)
				stat_q[`STC_BIT_MATCH] <= 1'b1;
			if (capEv)
				stat_q[`STC_BIT_CAPEV] <= 1'b1;
			stat_q[7:2] <= 6'h00;
		end
	end
	assign irq = |(stat_q & mask_q);
	// ===========================================
	// read data, one cycle after strobe
	always @(posedge clk) begin
		if (rst) begin
			rdData <= 8'h00;
		end else if (rdEn) begin
			case (addr)
				`STC_ADDR_CTRL: rdData <= ctrl_q;
				// compare low is write-only, so reads pick count or capture
				`STC_ADDR_LOW: rdData <= capMode ? capture_q[7:0] : count_q[7:0];
				`STC_ADDR_HIGH: rdData <= capMode ? capture_q[15:8] : count_q[15:8];
				`STC_ADDR_STAT: rdData <= stat_q;
				`STC_ADDR_MASK: rdData <= mask_q;
				default: rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end
endmodule // stc_timer

// [verif/stc_timer_properties.sv]
`timescale 1ns/1ns
module stc_timer_props (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [7:0] wrData,
	input wire wrEn,
	input wire rdEn,
	input wire [7:0] rdData,
	input wire captureTrigger,
	input wire irq
);
	// ===========
	// port checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence wrCtrl; wrEn && addr == 8'hce; endsequence
	sequence rdLow; rdEn && addr == 8'hcf; endsequence
	AST_RD_IDLE: assert property (!rdEn |=> rdData == 8'h00) else $error("idle");
	AST_CTRL_RD: assert property (wrCtrl ##2 (rdEn && addr == 8'hce) |=>
		rdData == ($past(wrData, 3) & 8'hbf)) else $error("ctrl");
	AST_CTRL_B6: assert property (rdEn && addr == 8'hce |=> !rdData[6]) else $error("b6");
	AST_UNMAP: assert property (rdEn && addr == 8'h10 |=> rdData == 8'h00) else $error("map");
	AST_STAT_RD: assert property (rdEn && addr == 8'hd6 |=> rdData[7:2] == 0) else $error("st");
	AST_MASK_OFF: assert property (wrEn && addr == 8'hd7 && wrData == 0 |=> !irq) else $error("m");
	// pause clear, so count must stay at the cleared value
	AST_CLR_START: assert property ((wrCtrl and (wrData[5:0] == 6'h01)) ##2 rdLow |=>
		rdData == 8'h00) else $error("clr");
	AST_STOP_HOLD: assert property ((wrCtrl and (wrData == 0)) ##2 rdLow ##2 rdLow |=>
		rdData == $past(rdData, 2)) else $error("hold");
endmodule // stc_timer_props
bind stc_timer stc_timer_props u_props (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
	.wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .captureTrigger(captureTrigger), .irq(irq));

// [verif/test_stc_timer.sv]
`timescale 1ns/1ns
module test_stc_timer;
	reg clk = 0, rst = 1, wrEn = 0, rdEn = 0, captureTrigger = 0;
	reg [7:0] addr = 0, wrData = 0;
	wire [7:0] rdData;
	wire irq;
	int errorCnt, samplesChecked, n, cmp;
	bit [31:0] seed = 32'h2da2dc62;
	reg [7:0] adr [5] = '{8'hce, 8'hcf, 8'hd5, 8'hd6, 8'h10};
	stc_timer u_stc_timer (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData), .captureTrigger(captureTrigger), .irq(irq));
	initial forever #5 clk = ~clk;
	function automatic [31:0] xs(input [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task giveVerdict;
		$display("checks %0d errors %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			errorCnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// trailing idle cycle keeps strobes from being re-raised in one step
	task wr(input [7:0] a, input [7:0] d);
		wrEn <= 1; addr <= a; wrData <= d;
		@(posedge clk) wrEn <= 0;
		@(posedge clk);
	endtask
	task rd(input [7:0] a, input [7:0] e);
		rdEn <= 1; addr <= a;
		@(posedge clk) rdEn <= 0;
		#1 chk("rdData", e, rdData);
		@(posedge clk);
	endtask
	// ===========
	// main flow
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		for (n = 0; n < 5; n++) rd(adr[n], 8'h00);
		seed = xs(seed);
		wr(8'hce, seed[7:0] & 8'h7c);
		rd(8'hce, seed[7:0] & 8'h3c);
		wr(8'hce, 8'h81);
		rd(8'hcf, 8'h00);
		wr(8'hce, 8'h00);
		rd(8'hcf, 8'h00);
		rd(8'hcf, 8'h00);
		cmp = (seed[15:8] & 7) + 2;
		wr(8'hd5, 8'h00);
		wr(8'hcf, cmp[7:0]);
		wr(8'hd7, 8'h01);
		wr(8'hce, 8'h83);
		// sample irq 1 ns after each edge so the flop update of that edge is seen
		for (n = 0; n < 40 && irq !== 1; n++) @(posedge clk) #1;
		// fx/2: two cycles per count, plus prescaler start-up and status set latency
		chk("matchTime", 2 * cmp + 2, n);
		wr(8'hd7, 8'h00);
		chk("irq", 0, irq);
		wr(8'hce, 8'h00);
		rd(8'hd6, 8'h01);
		wr(8'hd6, 8'h01);
		rd(8'hd6, 8'h00);
		wr(8'hce, 8'ha1);
		captureTrigger <= 1;
		@(posedge clk) captureTrigger <= 0;
		rd(8'hd6, 8'h02);
		rd(8'hcf, 8'h00);
		rd(8'hd5, 8'h00);
		giveVerdict;
	end
	initial begin
		#100000;
		errorCnt++;
		giveVerdict;
	end
endmodule // test_stc_timer
